// >>> design/tsd_pkg.sv
// Constants, register map and types for the temperature and DAC update block
// ----------------------------------------------------------------------------
// Contract
// RULE_01: While enabled, temperature conversions repeat back to back in the background.
// RULE_02: Clearing the sensor enable bit 3 stops temperature conversions.
// RULE_03: Finished result lands in bits 11:0 of the temperature result register.
// RULE_04: Result is two's complement, 0.125 degC per LSB.
// RULE_05: Result register holds still while a read transfer is moving it out.
// RULE_06: Rate field bits 2:0; code 7 is 15 ms, lower codes double per step.
// RULE_07: Reference enable bit 13 selects internal buffered reference and drives pin.
// RULE_08: Reference enable bit reads zero after reset, selecting external reference.
// RULE_09: Four DAC channels, each a 10-bit data register ahead of 10-bit latch.
// RULE_10: After reset, DAC buffers powered down, outputs high-Z, data and latches default.
// RULE_11: Reading a DAC data register returns that channel's latch code.
// RULE_12: Sync bit 0: writing data register updates the latch at once.
// RULE_13: Sync bit 1: latch waits for a 1 written to load bit 11.
// RULE_14: Load strobe reloads only channels written since the previous load.
// RULE_15: Load bit self clears; written flag clears when that latch reloads.
// ----------------------------------------------------------------------------
package tsd_pkg;

  // --------------------------------------------------------------------------
  // Register offsets (byte addresses)
  // --------------------------------------------------------------------------
  localparam logic [11:0] OFS_TEMP_CFG = 12'h000;
  localparam logic [11:0] OFS_TEMP_RES = 12'h004;
  localparam logic [11:0] OFS_POWER = 12'h008;
  localparam logic [11:0] OFS_CONFIG = 12'h00c;
  localparam logic [11:0] OFS_DAC_SYNC = 12'h010;
  localparam logic [11:0] OFS_DAC_PWR = 12'h014;
  localparam logic [11:0] OFS_DAC_BASE = 12'h020;

  // --------------------------------------------------------------------------
  // Field positions and widths
  // --------------------------------------------------------------------------
  localparam int TEMP_EN_BIT = 3;
  localparam int RATE_W = 3;
  localparam int REF_ON_BIT = 13;
  localparam int LOAD_BIT = 11;
  localparam int TEMP_W = 12;
  localparam int DAC_W = 10;
  localparam int DAC_N = 4;

  // --------------------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------------------
  localparam logic TEMP_EN_RST = 1'b1;
  localparam logic [2:0] RATE_RST = 3'h7;
  localparam logic REF_ON_RST = 1'b0;
  localparam logic [9:0] DAC_RST = 10'h000;
  localparam logic [11:0] TEMP_RST = 12'h000;

  // --------------------------------------------------------------------------
  // Timing: base conversion time and its cycle count at 10 MHz
  // --------------------------------------------------------------------------
  localparam int CLK_HZ = 10000000;
  localparam int CONV_MS = 15;
  localparam int CONV_CYC = CONV_MS * (CLK_HZ / 1000);

  // Converter sequencer states
  typedef enum logic [1:0] {TSD_IDLE, TSD_CONV, TSD_DONE} tsd_state_e;

endpackage

// >>> design/tsd_temp_conv.sv
// Background temperature conversion sequencer with frozen result register
`timescale 1ns/1ns
module tsd_temp_conv #(
  parameter int BASE_CYC = tsd_pkg::CONV_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Control
  input wire logic enable,
  input wire logic [2:0] rate,
  input wire logic freeze,
  // Sample from the analog front end
  input wire logic [11:0] sample,
  // Result
  output logic [11:0] result_q,
  output logic busy_q
);

  // Slowest setting is 128 times the base; keep counter wide enough
  localparam int CW = $clog2(BASE_CYC * 128 + 1);

  tsd_pkg::tsd_state_e state_q;
  tsd_pkg::tsd_state_e state_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic [CW-1:0] limit;
  logic [11:0] pend_q;
  logic pend_v_q;

  // Time shift: code 7 gives 1x, each step down doubles [RULE_06]
  assign limit = CW'(BASE_CYC) << (3'h7 - rate);

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      tsd_pkg::TSD_IDLE: begin
        cnt_d = '0;
        if (enable) state_d = tsd_pkg::TSD_CONV;
      end
      tsd_pkg::TSD_CONV: begin
        cnt_d = cnt_q + 1'b1;
        if (!enable) state_d = tsd_pkg::TSD_IDLE; // [RULE_02]
        else if (cnt_q >= limit - 1'b1) state_d = tsd_pkg::TSD_DONE;
      end
      default: begin
        cnt_d = '0;
        // Restart at once for continuous monitoring [RULE_01]
        state_d = enable ? tsd_pkg::TSD_CONV : tsd_pkg::TSD_IDLE;
      end
    endcase
  end

  // State, pending result and frozen register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= tsd_pkg::TSD_IDLE;
      cnt_q <= '0;
      pend_q <= tsd_pkg::TEMP_RST;
      pend_v_q <= 1'b0;
      result_q <= tsd_pkg::TEMP_RST;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      busy_q <= (state_d == tsd_pkg::TSD_CONV);
      if (state_q == tsd_pkg::TSD_DONE) begin
        pend_q <= sample; // Two's complement 0.125 C code [RULE_04]
        pend_v_q <= 1'b1;
      end else if (pend_v_q && !freeze) begin
        result_q <= pend_q; // Applied only when no read is shifting [RULE_05] [RULE_03]
        pend_v_q <= 1'b0;
      end
    end
  end

endmodule

// >>> design/tsd_dac_chan.sv
// One double-buffered DAC channel with written-since-load tracking
`timescale 1ns/1ns
module tsd_dac_chan #(
  parameter int W = tsd_pkg::DAC_W
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Control
  input wire logic wr,
  input wire logic [W-1:0] wdata,
  input wire logic sync_mode,
  input wire logic load,
  // State
  output logic [W-1:0] data_q,
  output logic [W-1:0] latch_q
);

  logic dirty_q;
  logic async_upd;
  logic sync_upd;

  // Async write goes straight through; sync waits for a load on dirty data
  assign async_upd = wr && !sync_mode; // [RULE_12]
  assign sync_upd = load && sync_mode && dirty_q; // [RULE_13] [RULE_14]

  // Registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_q <= W'(tsd_pkg::DAC_RST); // [RULE_10]
      latch_q <= W'(tsd_pkg::DAC_RST);
      dirty_q <= 1'b0;
    end else begin
      if (wr) data_q <= wdata;
      if (async_upd) latch_q <= wdata;
      else if (sync_upd) latch_q <= data_q;
      // A write in the same cycle as the reload keeps the flag set [RULE_15]
      if (wr && sync_mode) dirty_q <= 1'b1;
      else if (sync_upd || async_upd) dirty_q <= 1'b0;
    end
  end

endmodule

// >>> design/tsd_top.sv
// Temperature sensor control, reference select and DAC update logic on APB
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
module tsd_top #(
  parameter int CONV_CYC = tsd_pkg::CONV_CYC,
  parameter int NCH = tsd_pkg::DAC_N
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Temperature front end
  input wire logic [11:0] temp_sample,
  output logic temp_busy,
  // Reference control
  output logic ref_int_sel,
  output logic ref_pin_drive,
  // DAC outputs
  output logic [NCH*tsd_pkg::DAC_W-1:0] dac_analog_output,
  output logic [NCH-1:0] dac_buf_on
);

  localparam int DW = tsd_pkg::DAC_W;

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  function automatic logic [11:0] dac_ofs(input int idx);
    dac_ofs = tsd_pkg::OFS_DAC_BASE + 12'(idx * 4);
  endfunction

  logic acc;
  logic wr;
  logic rd;
  logic hit_tcfg;
  logic hit_tres;
  logic hit_pwr;
  logic hit_cfg;
  logic hit_sync;
  logic hit_dpwr;
  logic [NCH-1:0] hit_dac;
  logic hit_any;

  // Taken once, in the first access cycle; a second take would double the load strobe
  assign acc = psel && penable;
  assign wr = acc && pwrite && !pready;
  assign rd = acc && !pwrite && !pready;
  assign hit_tcfg = (paddr == tsd_pkg::OFS_TEMP_CFG);
  assign hit_tres = (paddr == tsd_pkg::OFS_TEMP_RES);
  assign hit_pwr = (paddr == tsd_pkg::OFS_POWER);
  assign hit_cfg = (paddr == tsd_pkg::OFS_CONFIG);
  assign hit_sync = (paddr == tsd_pkg::OFS_DAC_SYNC);
  assign hit_dpwr = (paddr == tsd_pkg::OFS_DAC_PWR);
  generate
    for (genvar g = 0; g < NCH; g++) begin : g_hit
      assign hit_dac[g] = (paddr == dac_ofs(g));
    end
  endgenerate
  assign hit_any = hit_tcfg | hit_tres | hit_pwr | hit_cfg | hit_sync | hit_dpwr | (|hit_dac);

  // --------------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------------
  logic temp_en_q;
  logic [2:0] rate_q;
  logic ref_on_q;
  logic [NCH-1:0] sync_q;
  logic [NCH-1:0] pwr_q;
  logic load_q;

  // Software writable fields; load is a self clearing strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_en_q <= tsd_pkg::TEMP_EN_RST;
      rate_q <= tsd_pkg::RATE_RST;
      ref_on_q <= tsd_pkg::REF_ON_RST; // [RULE_08]
      sync_q <= '0;
      pwr_q <= '0; // [RULE_10]
      load_q <= 1'b0;
    end else begin
      load_q <= wr && hit_cfg && pwdata[tsd_pkg::LOAD_BIT]; // [RULE_15] [RULE_13]
      if (wr && hit_tcfg) begin
        temp_en_q <= pwdata[tsd_pkg::TEMP_EN_BIT]; // [RULE_02]
        rate_q <= pwdata[tsd_pkg::RATE_W-1:0]; // [RULE_06]
      end
      if (wr && hit_pwr) ref_on_q <= pwdata[tsd_pkg::REF_ON_BIT]; // [RULE_07]
      if (wr && hit_sync) sync_q <= pwdata[NCH-1:0];
      if (wr && hit_dpwr) pwr_q <= pwdata[NCH-1:0];
    end
  end

  // --------------------------------------------------------------------------
  // Temperature converter
  // --------------------------------------------------------------------------
  logic [11:0] temp_res;
  logic busy;
  logic freeze;

  // Freeze while a read of the result is in flight
  assign freeze = psel && !pwrite && hit_tres; // [RULE_05]

  tsd_temp_conv #(
    .BASE_CYC(CONV_CYC)
  ) u_conv (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .enable(temp_en_q), // [RULE_01]
    .rate(rate_q),
    .freeze(freeze),
    .sample(temp_sample),
    .result_q(temp_res),
    .busy_q(busy)
  );

  // --------------------------------------------------------------------------
  // DAC channels
  // --------------------------------------------------------------------------
  logic [DW-1:0] latch [NCH];

  generate
    for (genvar c = 0; c < NCH; c++) begin : g_dac
      tsd_dac_chan #(
        .W(DW)
      ) u_chan (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .wr(wr && hit_dac[c]),
        .wdata(pwdata[DW-1:0]),
        .sync_mode(sync_q[c]),
        .load(load_q),
        .data_q(),
        .latch_q(latch[c]) // [RULE_09]
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------------
  logic [31:0] rmux;

  // DAC reads return the latch, not the data register
  always_comb begin
    rmux = 32'h0000_0000;
    if (hit_tcfg) begin
      rmux[tsd_pkg::TEMP_EN_BIT] = temp_en_q;
      rmux[tsd_pkg::RATE_W-1:0] = rate_q;
    end else if (hit_tres) begin
      rmux[tsd_pkg::TEMP_W-1:0] = temp_res; // [RULE_03]
    end else if (hit_pwr) begin
      rmux[tsd_pkg::REF_ON_BIT] = ref_on_q;
    end else if (hit_sync) begin
      rmux[NCH-1:0] = sync_q;
    end else if (hit_dpwr) begin
      rmux[NCH-1:0] = pwr_q;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (hit_dac[i]) rmux[DW-1:0] = latch[i]; // [RULE_11]
      end
    end
  end

  // --------------------------------------------------------------------------
  // Registered outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      temp_busy <= 1'b0;
      ref_int_sel <= 1'b0;
      ref_pin_drive <= 1'b0;
      dac_analog_output <= '0;
      dac_buf_on <= '0;
    end else begin
      // Answer in the second access cycle; unmapped gives pslverr
      pready <= acc && !pready;
      pslverr <= acc && !pready && !hit_any;
      prdata <= (rd && !pready) ? rmux : 32'h0000_0000;
      temp_busy <= busy;
      ref_int_sel <= ref_on_q; // [RULE_07]
      ref_pin_drive <= ref_on_q;
      dac_buf_on <= pwr_q; // [RULE_10]
      for (int i = 0; i < NCH; i++) begin
        dac_analog_output[i*DW +: DW] <= latch[i];
      end
    end
  end

endmodule

// >>> verification/tsd_front_model.sv
// Temperature front end model presenting digitized sensor codes
`timescale 1ns/1ns
module tsd_front_model (
  // Clock
  input wire logic sys_clk,
  // Code chosen by the bench
  input wire logic [11:0] code,
  // Digitized sensor value
  output logic [11:0] temp_sample
);
  // Two's complement code, 0.125 C per step
  always @(posedge sys_clk) begin
    temp_sample <= code;
  end
endmodule

// >>> verification/tsd_chk.sv
// Checker for bus answer, reference and DAC output timing
`timescale 1ns/1ns
module tsd_chk #(
  parameter int CONV_CYC = 10,
  parameter int NCH = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Device outputs
  input wire logic temp_busy,
  input wire logic ref_int_sel,
  input wire logic ref_pin_drive,
  input wire logic [NCH*tsd_pkg::DAC_W-1:0] dac_analog_output,
  input wire logic [NCH-1:0] dac_buf_on
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Taken writes; reference and buffer outputs may only move one or two edges later, DAC outputs up to three
  wire wr_hit = psel && penable && pwrite && !pready;
  wire pwr_wr = wr_hit && paddr == tsd_pkg::OFS_POWER;
  sequence acc_s;
    psel && penable && !pready;
  endsequence
  sequence pulse_s;
    pready ##1 !pready;
  endsequence
  ans_lat_a: assert property (acc_s |=> pulse_s) else $error("pready not a 1-cycle answer");
  err_pair_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  rd_idle_a: assert property ((!pready || pwrite) |-> prdata == 32'h0)
    else $error("prdata not zero");
  ref_pin_a: assert property (ref_int_sel == ref_pin_drive) else $error("ref pin differs");
  ref_cause_a: assert property ($changed(ref_int_sel) |-> $past(pwr_wr) || $past(pwr_wr, 2))
    else $error("ref select moved alone");
  dac_cause_a: assert property ($changed(dac_analog_output) |-> $past(wr_hit) || $past(wr_hit, 2)
    || $past(wr_hit, 3))
    else $error("dac output moved alone");
  buf_cause_a: assert property ($changed(dac_buf_on) |-> $past(wr_hit) || $past(wr_hit, 2))
    else $error("buffer power moved alone");
  rst_out_a: assert property ($rose(rst_n) |-> dac_analog_output == '0 && dac_buf_on == '0
    && !ref_int_sel) else $error("outputs not cleared by reset");
  conv_run_a: assert property ($rose(rst_n) |-> ##[0:3] temp_busy)
    else $error("converter did not start");
endmodule
bind tsd_top tsd_chk #(.CONV_CYC(CONV_CYC), .NCH(NCH)) u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .temp_busy(temp_busy), .ref_int_sel(ref_int_sel),
  .ref_pin_drive(ref_pin_drive), .dac_analog_output(dac_analog_output), .dac_buf_on(dac_buf_on));

// >>> verification/tb_top.sv
// Self-checking bench for the temperature and DAC update block
`timescale 1ns/1ns
module tb_top;
  localparam int CC = 10;
  logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h0, code = 12'h0c8, temp_sample;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic pready, pslverr, er, temp_busy, ref_int_sel, ref_pin_drive;
  logic [39:0] dac_analog_output;
  logic [3:0] dac_buf_on;
  int mismatches = 0, n_compared = 0, k, len, ex;

  tsd_top #(.CONV_CYC(CC), .NCH(4)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .temp_sample(temp_sample), .temp_busy(temp_busy),
    .ref_int_sel(ref_int_sel), .ref_pin_drive(ref_pin_drive),
    .dac_analog_output(dac_analog_output), .dac_buf_on(dac_buf_on));
  tsd_front_model i_fe (.sys_clk(sys_clk), .code(code), .temp_sample(temp_sample));

  // 100 ns clock
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  task tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task chk(input string n, input logic [39:0] e, input logic [39:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  function automatic logic [11:0] dac(input int n);
    return tsd_pkg::OFS_DAC_BASE + 12'(4 * n);
  endfunction

  // One APB transfer; pready and the answer are taken at the rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      tally_and_finish;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdc(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, 40'(e), 40'(rd));
  endtask

  // Busy-high length of one full conversion, bounded waits
  task busy_len;
    k = 0;
    while (temp_busy !== 1'b0 && k < 3000) begin @(negedge sys_clk); k++; end
    while (temp_busy !== 1'b1 && k < 3000) begin @(negedge sys_clk); k++; end
    len = 0;
    while (temp_busy === 1'b1 && k < 3000) begin @(negedge sys_clk); k++; len++; end
    if (k >= 3000) begin
      mismatches++;
      tally_and_finish;
    end
  endtask

  initial begin
    wt(5);
    rst_n <= 1'b1;
    rdc("temp_cfg", tsd_pkg::OFS_TEMP_CFG, 32'hf);
    rdc("power", tsd_pkg::OFS_POWER, 32'h0);
    chk("dac_out", 40'h0, dac_analog_output);
    chk("buf_on", 40'h0, 40'(dac_buf_on));
    $display("test reset done");
    apb(1'b1, tsd_pkg::OFS_POWER, 32'h2000);
    apb(1'b1, tsd_pkg::OFS_DAC_PWR, 32'hf);
    wt(2);
    chk("ref_sel", 40'h1, 40'(ref_int_sel));
    chk("ref_pin", 40'h1, 40'(ref_pin_drive));
    chk("buf_on", 40'hf, 40'(dac_buf_on));
    $display("test reference done");
    // Immediate update on every channel, top codes
    for (int n = 0; n < 4; n++) begin
      apb(1'b1, dac(n), 32'h3f0 + n);
      wt(2);
      chk("dac_out", 40'h3f0 + n, 40'(dac_analog_output[n*10 +: 10]));
      rdc("dac_rd", dac(n), 32'h3f0 + n);
    end
    $display("test async done");
    // Channels 0 and 1 wait for the load strobe
    apb(1'b1, tsd_pkg::OFS_DAC_SYNC, 32'h3);
    apb(1'b1, dac(0), 32'h155);
    wt(2);
    chk("dac0", 40'h3f0, 40'(dac_analog_output[9:0]));
    rdc("dac_rd", dac(0), 32'h3f0);
    apb(1'b1, tsd_pkg::OFS_CONFIG, 32'h800);
    wt(2);
    chk("dac0", 40'h155, 40'(dac_analog_output[9:0]));
    chk("dac1", 40'h3f1, 40'(dac_analog_output[19:10]));
    apb(1'b1, dac(1), 32'h2aa);
    apb(1'b1, tsd_pkg::OFS_CONFIG, 32'h800);
    wt(2);
    chk("dac1", 40'h2aa, 40'(dac_analog_output[19:10]));
    chk("dac0", 40'h155, 40'(dac_analog_output[9:0]));
    rdc("config", tsd_pkg::OFS_CONFIG, 32'h0);
    $display("test sync done");
    apb(1'b0, 12'hffc, 32'h0);
    chk("slverr", 40'h1, 40'(er));
    chk("unmapped", 40'h0, 40'(rd));
    // Temperature codes reach the result register
    wt(40);
    rdc("temp", tsd_pkg::OFS_TEMP_RES, 32'h0c8);
    code <= 12'hff8;
    wt(40);
    rdc("temp", tsd_pkg::OFS_TEMP_RES, 32'hff8);
    for (int r = 7; r >= 0; r--) begin
      apb(1'b1, tsd_pkg::OFS_TEMP_CFG, 32'h8 | r);
      busy_len;
      ex = CC << (7 - r);
      chk("conv_len", 40'h1, 40'(len >= ex && len <= ex + 1));
    end
    $display("test temperature done");
    apb(1'b1, tsd_pkg::OFS_TEMP_CFG, 32'h7);
    wt(3);
    k = 0;
    repeat (60) begin
      @(negedge sys_clk);
      if (temp_busy !== 1'b0) k++;
    end
    chk("busy_off", 40'h0, 40'(k));
    $display("test disable done");
    tally_and_finish;
  end
endmodule
